// ### shared/tpw_regs.svh
// Purpose: Register map, field positions, reset values and rates of the timer
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus
// Notes:   Definitions only
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// Rates
`define TPW_SYS_MHZ       7'd100
`define TPW_PCLK_MHZ      7'd16
`define TPW_DIV_FAST      10'd4
`define TPW_DIV_SLOW      10'd512

// Byte offsets
`define TPW_OFS_CTRL      8'h00
`define TPW_OFS_RELOAD    8'h04
`define TPW_OFS_COUNT     8'h08
`define TPW_OFS_PWM_HIGH  8'h0c
`define TPW_OFS_PWM_LOW   8'h10
`define TPW_OFS_STATUS    8'h14
`define TPW_OFS_INT_CLR   8'h18
`define TPW_OFS_INT_EN    8'h1c
`define TPW_OFS_STATE     8'h20

// Control fields
`define TPW_CTRL_RUN      0
`define TPW_CTRL_SLOW     1
`define TPW_CTRL_PWM      2
`define TPW_CTRL_W        3

// Status, clear and enable fields
`define TPW_EV_PERIOD     0
`define TPW_EV_PWM        1
`define TPW_EV_W          2

// State fields
`define TPW_ST_LEVEL      0
`define TPW_ST_RUNNING    1

// Reset values
`define TPW_RST_CTRL      3'h0
`define TPW_RST_RELOAD    16'hffff
`define TPW_RST_PWM_HIGH  8'h80
`define TPW_RST_PWM_LOW   8'h80

// Bus responses
`define TPW_RESP_OKAY     2'b00
`define TPW_RESP_SLVERR   2'b10

`endif

// ### shared/tpw_pkg.sv
// Purpose: Types shared by the timer design
// Assumes: Constants live in tpw_regs.svh
// Notes:   Gray coded PWM phases along idle, high, low
package tpw_pkg;
  typedef enum logic [1:0] {
    TPW_IDLE = 2'b00,
    TPW_HIGH = 2'b01,
    TPW_LOW  = 2'b11
  } tpw_phase_e;
  typedef logic [15:0] tpw_count_t;
  typedef logic [7:0]  tpw_len_t;
endpackage

// ### src/tpw_prescaler.sv
// Purpose: Count tick enable from the system clock, via a 16 MHz base rate
// Assumes: One clock domain; run restarts the divider
// Notes:   16 MHz is an average rate made by a phase accumulator
`timescale 1ns/10ps
`include "tpw_regs.svh"
module tpw_prescaler
  import tpw_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic run,
  input  wire logic slow_sel,
  // Tick
  output logic      tick
);
  logic [6:0] acc_ff;
  logic [8:0] div_ff;
  logic [6:0] acc_sum;
  logic       pclk_en;
  logic [8:0] div_last;
  logic [9:0] div_span;
  logic [9:0] div_end;

  // Base rate of the peripheral clock
  assign acc_sum  = acc_ff + `TPW_PCLK_MHZ;
  assign pclk_en  = acc_sum >= `TPW_SYS_MHZ;
  // 512 needs ten bits; the last count fits in nine
  assign div_span = slow_sel ? `TPW_DIV_SLOW : `TPW_DIV_FAST;
  assign div_end  = div_span - 10'd1;
  assign div_last = div_end[8:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= 7'h00;
      div_ff <= 9'h000;
      tick   <= 1'b0;
    end else begin
      acc_ff <= pclk_en ? acc_sum - `TPW_SYS_MHZ : acc_sum;
      tick   <= 1'b0;
      if (!run) begin
        div_ff <= 9'h000;
      end else if (pclk_en) begin
        div_ff <= (div_ff >= div_last) ? 9'h000 : div_ff + 9'd1;
        tick   <= div_ff >= div_last;
      end
    end
  end
endmodule

// ### src/tpw_timer.sv
// Purpose: 16-bit auto-reload timer with PWM mode and AXI4-Lite registers
// Assumes: aclk at 100 MHz; synchronous active-low reset
// Notes:   Output pin is driven only while PWM mode runs
//
// Function
// - The timer has a 16-bit counter that software can read to poll progress.
// - Software may poll the period flag or let it raise an interrupt request.
// - The counter auto-reloads its programmed value each period, ticking at clock/4 or /512.
// - A PWM mode drives the generated waveform on the dedicated output pin.
// - In PWM mode one 8-bit register sets the high phase and another the low phase.
// - The PWM phases are counted with the same /4 or /512 prescaled tick.
// - The timer runs from a 16 MHz peripheral clock ahead of the prescaler.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "tpw_regs.svh"
module tpw_timer
  import tpw_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt
  output logic             irq,
  // PWM pin
  output logic             pwm_output_pin_o,
  output logic             pwm_output_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [`TPW_CTRL_W-1:0] ctrl_ff;
  tpw_count_t             reload_ff;
  tpw_count_t             count_ff;
  tpw_len_t               high_ff;
  tpw_len_t               low_ff;
  logic [`TPW_EV_W-1:0]   status_ff;
  logic [`TPW_EV_W-1:0]   int_en_ff;
  tpw_phase_e             phase_ff;
  tpw_len_t               ph_cnt_ff;
  logic                   run_d_ff;

  logic                   aw_held_ff;
  logic                   w_held_ff;
  logic [7:0]             awaddr_ff;
  logic [31:0]            wdata_ff;
  logic [3:0]             wstrb_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_known(input logic [7:0] a);
    return a == `TPW_OFS_CTRL || a == `TPW_OFS_RELOAD || a == `TPW_OFS_COUNT ||
           a == `TPW_OFS_PWM_HIGH || a == `TPW_OFS_PWM_LOW || a == `TPW_OFS_STATUS ||
           a == `TPW_OFS_INT_CLR || a == `TPW_OFS_INT_EN || a == `TPW_OFS_STATE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Prescaled tick

  logic run;
  logic pwm_mode;
  logic tick;

  assign run      = ctrl_ff[`TPW_CTRL_RUN];
  assign pwm_mode = ctrl_ff[`TPW_CTRL_PWM];

  tpw_prescaler u_prescaler (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (run),
    .slow_sel (ctrl_ff[`TPW_CTRL_SLOW]),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Auto-reload counter

  logic       run_rise;
  logic       cnt_wrap;
  tpw_count_t nxt_count;

  assign run_rise  = run && !run_d_ff;
  assign cnt_wrap  = run && !pwm_mode && tick && count_ff == 16'h0000;
  assign nxt_count = run_rise ? reload_ff :
                     !(run && !pwm_mode && tick) ? count_ff :
                     cnt_wrap ? reload_ff :
                     count_ff - 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // PWM phase machine

  logic       ph_done;
  logic       pwm_wrap;
  tpw_phase_e nxt_phase;
  tpw_len_t   nxt_ph_cnt;

  // A zero length skips its phase unless both lengths are zero (pin then stays high), so the pin never shows a stray tick
  function automatic tpw_phase_e enter_high(input tpw_len_t hi, input tpw_len_t lo);
    return (hi == 8'h00 && lo != 8'h00) ? TPW_LOW : TPW_HIGH;
  endfunction

  function automatic tpw_phase_e enter_low(input tpw_len_t hi, input tpw_len_t lo);
    return (lo == 8'h00) ? TPW_HIGH : TPW_LOW;
  endfunction

  assign ph_done = tick && ((phase_ff == TPW_HIGH) ? ph_cnt_ff + 8'd1 >= high_ff
                                                   : ph_cnt_ff + 8'd1 >= low_ff);
  assign pwm_wrap = run && pwm_mode && ph_done && phase_ff == TPW_LOW;

  always_comb begin
    nxt_phase  = phase_ff;
    nxt_ph_cnt = ph_cnt_ff;
    if (!(run && pwm_mode)) begin
      nxt_phase  = TPW_IDLE;
      nxt_ph_cnt = 8'h00;
    end else begin
      unique case (phase_ff)
        TPW_IDLE: begin
          nxt_phase  = enter_high(high_ff, low_ff);
          nxt_ph_cnt = 8'h00;
        end
        TPW_HIGH: begin
          if (ph_done) begin
            nxt_phase  = enter_low(high_ff, low_ff);
            nxt_ph_cnt = 8'h00;
          end else if (tick) begin
            nxt_ph_cnt = ph_cnt_ff + 8'd1;
          end
        end
        TPW_LOW: begin
          if (ph_done) begin
            nxt_phase  = enter_high(high_ff, low_ff);
            nxt_ph_cnt = 8'h00;
          end else if (tick) begin
            nxt_ph_cnt = ph_cnt_ff + 8'd1;
          end
        end
        default: begin
          nxt_phase  = TPW_IDLE;
          nxt_ph_cnt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff  <= `TPW_RST_RELOAD;
      phase_ff  <= TPW_IDLE;
      ph_cnt_ff <= 8'h00;
      run_d_ff  <= 1'b0;
    end else begin
      count_ff  <= nxt_count;
      phase_ff  <= nxt_phase;
      ph_cnt_ff <= nxt_ph_cnt;
      run_d_ff  <= run;
    end
  end

  // Pin follows the next phase so it is a flop aligned with phase_ff
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_output_pin_o    <= 1'b0;
      pwm_output_pin_oe_n <= 1'b1;
    end else begin
      pwm_output_pin_o    <= nxt_phase == TPW_HIGH;
      pwm_output_pin_oe_n <= !(run && pwm_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel

  logic wr_fire;
  logic wr_known;
  logic wr_ctrl;
  logic wr_reload;
  logic wr_high;
  logic wr_low;
  logic wr_clr;
  logic wr_en;
  logic [31:0] wr_val;
  logic [31:0] strb_mask;
  logic [`TPW_EV_W-1:0] clr_bits;
  logic [`TPW_EV_W-1:0] ev_bits;

  assign wr_fire   = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_known  = addr_known(awaddr_ff);
  assign wr_ctrl   = wr_fire && awaddr_ff == `TPW_OFS_CTRL;
  assign wr_reload = wr_fire && awaddr_ff == `TPW_OFS_RELOAD;
  assign wr_high   = wr_fire && awaddr_ff == `TPW_OFS_PWM_HIGH;
  assign wr_low    = wr_fire && awaddr_ff == `TPW_OFS_PWM_LOW;
  assign wr_clr    = wr_fire && awaddr_ff == `TPW_OFS_INT_CLR;
  assign wr_en     = wr_fire && awaddr_ff == `TPW_OFS_INT_EN;
  assign strb_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_val    = wdata_ff & strb_mask;
  assign clr_bits  = wr_clr ? wr_val[`TPW_EV_W-1:0] : '0;
  assign ev_bits   = {pwm_wrap, cnt_wrap};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TPW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff    <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held_ff && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff    <= 1'b1;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held_ff && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff   <= `TPW_RST_CTRL;
      reload_ff <= `TPW_RST_RELOAD;
      high_ff   <= `TPW_RST_PWM_HIGH;
      low_ff    <= `TPW_RST_PWM_LOW;
      int_en_ff <= '0;
      status_ff <= '0;
      irq       <= 1'b0;
    end else begin
      // Unstrobed byte lanes keep their old value
      if (wr_ctrl) begin
        ctrl_ff <= wr_val[`TPW_CTRL_W-1:0] | (ctrl_ff & ~strb_mask[`TPW_CTRL_W-1:0]);
      end
      if (wr_reload) begin
        reload_ff <= wr_val[15:0] | (reload_ff & ~strb_mask[15:0]);
      end
      if (wr_high) begin
        high_ff <= wr_val[7:0] | (high_ff & ~strb_mask[7:0]);
      end
      if (wr_low) begin
        low_ff <= wr_val[7:0] | (low_ff & ~strb_mask[7:0]);
      end
      if (wr_en) begin
        int_en_ff <= wr_val[`TPW_EV_W-1:0] | (int_en_ff & ~strb_mask[`TPW_EV_W-1:0]);
      end
      // New events win over a clear in the same cycle
      status_ff <= (status_ff & ~clr_bits) | ev_bits;
      irq       <= |(((status_ff & ~clr_bits) | ev_bits) & int_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [31:0] rd_val;
  logic        rd_known;

  assign rd_known = addr_known(s_axi_araddr);
  assign rd_val =
    (s_axi_araddr == `TPW_OFS_CTRL)     ? {29'h0, ctrl_ff}   :
    (s_axi_araddr == `TPW_OFS_RELOAD)   ? {16'h0, reload_ff} :
    (s_axi_araddr == `TPW_OFS_COUNT)    ? {16'h0, count_ff}  :
    (s_axi_araddr == `TPW_OFS_PWM_HIGH) ? {24'h0, high_ff}   :
    (s_axi_araddr == `TPW_OFS_PWM_LOW)  ? {24'h0, low_ff}    :
    (s_axi_araddr == `TPW_OFS_STATUS)   ? {30'h0, status_ff} :
    (s_axi_araddr == `TPW_OFS_INT_EN)   ? {30'h0, int_en_ff} :
    (s_axi_araddr == `TPW_OFS_STATE)    ? {30'h0, run, phase_ff == TPW_HIGH} :
    32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TPW_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_known ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ### test/tpw_timer_properties.sv
// Purpose: Bus and pin properties of the timer, seen at its ports
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every instance of the timer
`timescale 1ns/10ps
`include "tpw_regs.svh"
module tpw_timer_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pin
  input wire logic        pwm_output_pin_o,
  input wire logic        pwm_output_pin_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("late write response");
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("late read data");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("second write taken");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("second read taken");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == `TPW_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  // A phase is at least one fast tick, far above eight cycles
  property p_high_min;
    $rose(pwm_output_pin_o) && !pwm_output_pin_oe_n
      |=> (pwm_output_pin_o || pwm_output_pin_oe_n)[*8];
  endproperty
  a_high_min: assert property (p_high_min) else $error("high phase too short");
  property p_low_min;
    $fell(pwm_output_pin_o) && !pwm_output_pin_oe_n
      |=> (!pwm_output_pin_o || pwm_output_pin_oe_n)[*8];
  endproperty
  a_low_min: assert property (p_low_min) else $error("low phase too short");
endmodule
bind tpw_timer tpw_timer_properties tpw_timer_properties_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pwm_output_pin_o(pwm_output_pin_o),
  .pwm_output_pin_oe_n(pwm_output_pin_oe_n));

// ### test/tpw_pin_load.sv
// Purpose: Load on the PWM pin that times its phases
// Assumes: Weak pull-up holds the released pin
// Notes:   Lengths are in clock cycles of the last whole phases
`timescale 1ns/10ps
module tpw_pin_load #(parameter logic PULL_LVL = 1'b1) (
  // Clock
  input  wire logic  aclk,
  // Pin
  input  wire logic  pin_o,
  input  wire logic  pin_oe_n,
  // Measurements
  output logic [15:0] high_len,
  output logic [15:0] low_len,
  output logic [7:0]  n_per
);
  logic        line;
  logic        prev;
  logic        seen_edge;
  logic [15:0] cnt;
  // Released pin goes to the pull level, never the last driven value
  assign line = pin_oe_n ? PULL_LVL : pin_o;
  always @(posedge aclk) begin
    prev <= line;
    if (pin_oe_n) begin
      seen_edge <= 1'b0;
      cnt       <= 16'h0;
      n_per     <= 8'h0;
    end else if (line !== prev) begin
      cnt       <= 16'h1;
      seen_edge <= 1'b1;
      if (seen_edge && prev) high_len <= cnt;
      if (seen_edge && !prev) begin
        low_len <= cnt;
        n_per   <= n_per + 8'h1;
      end
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
endmodule

// ### test/general_timer_with_pwm_test.sv
// Purpose: Register, counter, interrupt and PWM tests of the timer
// Assumes: 100 MHz clock; /4 tick is exactly 25 cycles
// Notes:   Bus tasks raise ready only after valid, to exercise stalls
`timescale 1ns/10ps
`include "tpw_regs.svh"
module general_timer_with_pwm_test;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, d2;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, pin, oe_n;
  logic [15:0] hi_len, lo_len;
  logic [7:0]  n_per;
  longint      t1, t2;
  int          miscompares, num_checks, i, tk;
  tpw_timer tpw_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .pwm_output_pin_o(pin), .pwm_output_pin_oe_n(oe_n));
  tpw_pin_load tpw_pin_load_i (.aclk(aclk), .pin_o(pin), .pin_oe_n(oe_n),
    .high_len(hi_len), .low_len(lo_len), .n_per(n_per));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task near(input longint seen, input longint exp);
    chk(seen >= exp - 2 && seen <= exp + 2, 1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  // Clear, let the registered irq fall, then wait for the next event
  task clr_wait(output longint t);
    wr(`TPW_OFS_INT_CLR, 32'h3);
    repeat (2) @(posedge aclk);
    while (irq !== 1'b1) @(posedge aclk);
    t = $time;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`TPW_OFS_CTRL, 32'h0);
    rchk(`TPW_OFS_RELOAD, 32'hffff);
    rchk(`TPW_OFS_COUNT, 32'hffff);
    rchk(`TPW_OFS_PWM_HIGH, 32'h80);
    rchk(`TPW_OFS_PWM_LOW, 32'h80);
    rchk(`TPW_OFS_STATUS, 32'h0);
    rchk(`TPW_OFS_INT_EN, 32'h0);
    rchk(8'h24, 32'h0);
    chk(r, `TPW_RESP_SLVERR);
    wr(8'h02, 32'h1);
    chk(r, `TPW_RESP_SLVERR);
    wstrb <= 4'h1;
    wr(`TPW_OFS_RELOAD, 32'h1234_5678);
    wstrb <= 4'hf;
    rchk(`TPW_OFS_RELOAD, 32'hff78);
    wr(`TPW_OFS_CTRL, 32'h1);
    rd(`TPW_OFS_COUNT);
    d2 = d;
    chk(d2, 32'hff78);
    // At least one 25-cycle tick before the second look
    repeat (30) @(posedge aclk);
    rd(`TPW_OFS_COUNT);
    chk(d < d2, 1);
    for (i = 0; i < 2; i++) begin
      wr(`TPW_OFS_CTRL, 32'h0);
      wr(`TPW_OFS_RELOAD, i ? 32'h0 : 32'h3);
      wr(`TPW_OFS_INT_EN, 32'h1);
      wr(`TPW_OFS_CTRL, i ? 32'h3 : 32'h1);
      clr_wait(t1);
      clr_wait(t2);
      near((t2 - t1) / 10, i ? 3200 : 100);
    end
    // Polling only: the flag still sets with the request masked
    wr(`TPW_OFS_INT_EN, 32'h0);
    wr(`TPW_OFS_INT_CLR, 32'h3);
    repeat (3300) @(posedge aclk);
    chk(irq, 1'b0);
    rchk(`TPW_OFS_STATUS, 32'h1);
    rchk(`TPW_OFS_STATE, 32'h2);
    rchk(`TPW_OFS_INT_CLR, 32'h0);
    for (i = 0; i < 2; i++) begin
      tk = i ? 3200 : 25;
      wr(`TPW_OFS_CTRL, 32'h0);
      wr(`TPW_OFS_INT_CLR, 32'h3);
      wr(`TPW_OFS_PWM_HIGH, i ? 32'h1 : 32'h3);
      wr(`TPW_OFS_PWM_LOW, i ? 32'h2 : 32'h5);
      wr(`TPW_OFS_CTRL, i ? 32'h7 : 32'h5);
      while (n_per < 8'h2) @(posedge aclk);
      chk(oe_n, 1'b0);
      near(hi_len, (i ? 1 : 3) * tk);
      near(lo_len, (i ? 2 : 5) * tk);
      rchk(`TPW_OFS_STATUS, 32'h2);
    end
    wr(`TPW_OFS_CTRL, 32'h0);
    repeat (2) @(posedge aclk);
    chk(oe_n, 1'b1);
    stop_test;
  end
endmodule
